// ### core/bscan_pkg.sv
// shared constants for the boundary-scan test access port
// assumes a 50 MHz system clock that oversamples the test clock pins
package bscan_pkg;
    localparam int CELLS_PER_IO = 3;
    localparam int IR_W = 3;
    // cell position inside one i/o group
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_SAMPLE = 3'h1;
    localparam logic [2:0] IR_HIGHZ = 3'h5;
    localparam logic [2:0] IR_CLAMP = 3'h6;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    // fixed pattern the instruction shifter captures
    localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
    localparam int CLK_HZ = 50000000;
    localparam int TCK_MAX_HZ = 20000000;
    // system clocks per fastest test clock period, rounded down
    localparam int TCK_MIN_CYC = CLK_HZ / TCK_MAX_HZ;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [15:0] {
        BSCAN_RESET = 16'h0001,
        BSCAN_IDLE = 16'h0002,
        BSCAN_SEL_DR = 16'h0004,
        BSCAN_CAP_DR = 16'h0008,
        BSCAN_SH_DR = 16'h0010,
        BSCAN_EX1_DR = 16'h0020,
        BSCAN_PAU_DR = 16'h0040,
        BSCAN_EX2_DR = 16'h0080,
        BSCAN_UPD_DR = 16'h0100,
        BSCAN_SEL_IR = 16'h0200,
        BSCAN_CAP_IR = 16'h0400,
        BSCAN_SH_IR = 16'h0800,
        BSCAN_EX1_IR = 16'h1000,
        BSCAN_PAU_IR = 16'h2000,
        BSCAN_EX2_IR = 16'h4000,
        BSCAN_UPD_IR = 16'h8000
    } bscan_state_t;
endpackage

// ### core/bscan_ctl_if.sv
// control bundle between the test controller and the boundary cell chain
// assumes both ends run on the same system clock
`timescale 1ns/1ns
interface bscan_ctl_if;
    logic capture;
    logic shift;
    logic update;
    logic sdi;
    logic sdo;
    logic pins_from_cells;
    logic core_from_cells;
    logic all_highz;
    modport ctl (output capture, output shift, output update, output sdi, output pins_from_cells,
        output core_from_cells, output all_highz, input sdo);
    modport chain (input capture, input shift, input update, input sdi, input pins_from_cells,
        input core_from_cells, input all_highz, output sdo);
endinterface

// ### core/bscan_chain.sv
// boundary register: three cells per i/o, serial chain plus pin/core muxing
// assumes one-cycle capture/shift/update strobes from the test controller
`timescale 1ns/1ns
module bscan_chain #(
    parameter int NUM_IO = 8
) (
    input wire logic clk,
    input wire logic reset,
    bscan_ctl_if.chain ctl,
    input wire logic [NUM_IO-1:0] pad_in,
    input wire logic [NUM_IO-1:0] core_out,
    input wire logic [NUM_IO-1:0] core_oe,
    output logic [NUM_IO-1:0] core_in,
    output logic [NUM_IO-1:0] pad_out,
    output logic [NUM_IO-1:0] pad_oe
);
    localparam int LEN = NUM_IO * bscan_pkg::CELLS_PER_IO;

    typedef struct packed {
        logic [NUM_IO-1:0] pin_s1;
        logic [NUM_IO-1:0] pin_s2;
        logic [LEN-1:0] sh;
        logic [LEN-1:0] upd;
        logic [NUM_IO-1:0] core_in;
        logic [NUM_IO-1:0] pad_out;
        logic [NUM_IO-1:0] pad_oe;
    } bscan_chain_st_t;

    bscan_chain_st_t st_r;
    bscan_chain_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_s1 = pad_in;
        st_nxt.pin_s2 = st_r.pin_s1;
        if (ctl.capture) begin
            for (int i = 0; i < NUM_IO; i++) begin
                // parallel inputs observe the pad and the core's drive
                st_nxt.sh[i*3+bscan_pkg::CELL_IN] = st_r.pin_s2[i]; // [RULE_03]
                st_nxt.sh[i*3+bscan_pkg::CELL_OUT] = core_out[i]; // [RULE_03]
                st_nxt.sh[i*3+bscan_pkg::CELL_OE] = core_oe[i]; // [RULE_03]
            end
        end else if (ctl.shift) begin
            st_nxt.sh = {ctl.sdi, st_r.sh[LEN-1:1]}; // [RULE_02]
        end
        if (ctl.update) begin
            st_nxt.upd = st_r.sh; // [RULE_01]
        end
        for (int i = 0; i < NUM_IO; i++) begin
            st_nxt.core_in[i] = ctl.core_from_cells ? st_r.upd[i*3+bscan_pkg::CELL_IN] : st_r.pin_s2[i];
            st_nxt.pad_out[i] = ctl.pins_from_cells ? st_r.upd[i*3+bscan_pkg::CELL_OUT] : core_out[i]; // [RULE_03]
            st_nxt.pad_oe[i] = ctl.pins_from_cells ? st_r.upd[i*3+bscan_pkg::CELL_OE] : core_oe[i];
            if (ctl.all_highz) begin
                st_nxt.pad_oe[i] = 1'b0; // [RULE_11]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ctl.sdo = st_r.sh[0]; // [RULE_02]
    assign core_in = st_r.core_in;
    assign pad_out = st_r.pad_out;
    assign pad_oe = st_r.pad_oe;
endmodule

// ### core/bscan_tap.sv
// boundary-scan test access port: tap controller, instruction register,
// bypass bit and the boundary cell chain
// assumes tck/tms/tdi arrive asynchronously and are oversampled by clk;
// tdo is a three-state pin split into value and enable
//
// Contract
// [RULE_01] every i/o owns three boundary cells, each with serial and parallel in and out.
// [RULE_02] all cells form one serial chain fed from tdi and read out at tdo.
// [RULE_03] cell parallel ports observe pads and core and can drive pad value and enable.
// [RULE_04] tms is sampled on each rising tck edge to walk the controller states.
// [RULE_05] tdi is sampled on the rising tck edge while shifting instruction or data.
// [RULE_06] tdo changes on the falling tck edge so the tester samples it on the next rise.
// [RULE_07] the tester keeps tck at or below 20 MHz.
// [RULE_08] tdo is driven only while shifting and is released otherwise.
// [RULE_09] code 000 drives pins from the cells and captures input pins into them.
// [RULE_10] code 001 snapshots the pins with normal operation running and allows preload.
// [RULE_11] code 101 releases every i/o to high impedance.
// [RULE_12] code 110 drives the pins from the held boundary values.
// [RULE_13] code 111 puts a one-bit bypass between tdi and tdo.
// [RULE_14] reset forces the controller into its test-logic-reset state.
// [RULE_15] a three-bit instruction register and the sixteen-state controller steered by tms.
// [RULE_16] codes 010, 011 and 100 behave as bypass.
`timescale 1ns/1ns
module bscan_tap #(
    parameter int NUM_IO = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [NUM_IO-1:0] pad_in,
    input wire logic [NUM_IO-1:0] core_out,
    input wire logic [NUM_IO-1:0] core_oe,
    output logic [NUM_IO-1:0] core_in,
    output logic [NUM_IO-1:0] pad_out,
    output logic [NUM_IO-1:0] pad_oe
);
    // refused at elaboration: the indexing and decode below are written for these sizes
    if (NUM_IO < 1) begin : g_bad_num_io
        $error("NUM_IO must be at least 1");
    end
    if (bscan_pkg::CELLS_PER_IO != 3) begin : g_bad_cells
        $error("cell indexing assumes three cells per i/o");
    end
    if (bscan_pkg::IR_W != 3) begin : g_bad_ir_w
        $error("instruction decode assumes a three-bit register");
    end
    // need at least two samples per test clock period to see both edges
    if (bscan_pkg::TCK_MIN_CYC < 2) begin : g_slow_clk
        $error("system clock too slow for the test clock");
    end

    typedef struct packed {
        logic tck_s1;
        logic tck_s2;
        logic tck_d;
        logic tms_s1;
        logic tms_s2;
        logic tdi_s1;
        logic tdi_s2;
        bscan_pkg::bscan_state_t state;
        logic [bscan_pkg::IR_W-1:0] ir;
        logic [bscan_pkg::IR_W-1:0] ir_sh;
        logic byp;
        logic tdo;
        logic tdo_oe;
        logic capture;
        logic shift;
        logic update;
        logic sdi;
    } bscan_tap_st_t;

    bscan_tap_st_t st_r;
    bscan_tap_st_t st_nxt;
    bscan_ctl_if ctl ();

    function automatic bscan_pkg::bscan_state_t bscan_next(input bscan_pkg::bscan_state_t s, input logic m);
        bscan_pkg::bscan_state_t n;
        n = bscan_pkg::BSCAN_RESET;
        unique case (s)
            bscan_pkg::BSCAN_RESET: n = m ? bscan_pkg::BSCAN_RESET : bscan_pkg::BSCAN_IDLE;
            bscan_pkg::BSCAN_IDLE: n = m ? bscan_pkg::BSCAN_SEL_DR : bscan_pkg::BSCAN_IDLE;
            bscan_pkg::BSCAN_SEL_DR: n = m ? bscan_pkg::BSCAN_SEL_IR : bscan_pkg::BSCAN_CAP_DR;
            bscan_pkg::BSCAN_CAP_DR: n = m ? bscan_pkg::BSCAN_EX1_DR : bscan_pkg::BSCAN_SH_DR;
            bscan_pkg::BSCAN_SH_DR: n = m ? bscan_pkg::BSCAN_EX1_DR : bscan_pkg::BSCAN_SH_DR;
            bscan_pkg::BSCAN_EX1_DR: n = m ? bscan_pkg::BSCAN_UPD_DR : bscan_pkg::BSCAN_PAU_DR;
            bscan_pkg::BSCAN_PAU_DR: n = m ? bscan_pkg::BSCAN_EX2_DR : bscan_pkg::BSCAN_PAU_DR;
            bscan_pkg::BSCAN_EX2_DR: n = m ? bscan_pkg::BSCAN_UPD_DR : bscan_pkg::BSCAN_SH_DR;
            bscan_pkg::BSCAN_UPD_DR: n = m ? bscan_pkg::BSCAN_SEL_DR : bscan_pkg::BSCAN_IDLE;
            bscan_pkg::BSCAN_SEL_IR: n = m ? bscan_pkg::BSCAN_RESET : bscan_pkg::BSCAN_CAP_IR;
            bscan_pkg::BSCAN_CAP_IR: n = m ? bscan_pkg::BSCAN_EX1_IR : bscan_pkg::BSCAN_SH_IR;
            bscan_pkg::BSCAN_SH_IR: n = m ? bscan_pkg::BSCAN_EX1_IR : bscan_pkg::BSCAN_SH_IR;
            bscan_pkg::BSCAN_EX1_IR: n = m ? bscan_pkg::BSCAN_UPD_IR : bscan_pkg::BSCAN_PAU_IR;
            bscan_pkg::BSCAN_PAU_IR: n = m ? bscan_pkg::BSCAN_EX2_IR : bscan_pkg::BSCAN_PAU_IR;
            bscan_pkg::BSCAN_EX2_IR: n = m ? bscan_pkg::BSCAN_UPD_IR : bscan_pkg::BSCAN_SH_IR;
            bscan_pkg::BSCAN_UPD_IR: n = m ? bscan_pkg::BSCAN_SEL_DR : bscan_pkg::BSCAN_IDLE;
            // a corrupted one-hot code falls back to reset
            default: n = bscan_pkg::BSCAN_RESET;
        endcase
        return n;
    endfunction

    // only extest and sample/preload put the boundary chain between tdi and tdo
    function automatic logic bscan_bsr_sel(input logic [2:0] code);
        return (code == bscan_pkg::IR_EXTEST) || (code == bscan_pkg::IR_SAMPLE); // [RULE_16]
    endfunction

    // tdo is driven in exactly these two states
    function automatic logic bscan_in_shift(input bscan_pkg::bscan_state_t s);
        return (s == bscan_pkg::BSCAN_SH_IR) || (s == bscan_pkg::BSCAN_SH_DR);
    endfunction

    // clamp keeps bypass in the data path but still drives pins from held values
    function automatic logic bscan_pins_sel(input logic [2:0] code);
        return (code == bscan_pkg::IR_EXTEST) || (code == bscan_pkg::IR_CLAMP); // [RULE_09] [RULE_12]
    endfunction

    // only extest hands the input cells to the core
    function automatic logic bscan_core_sel(input logic [2:0] code);
        return code == bscan_pkg::IR_EXTEST; // [RULE_09]
    endfunction

    logic tck_rise;
    logic tck_fall;
    logic bsr_sel;

    always_comb begin
        tck_rise = st_r.tck_s2 & ~st_r.tck_d;
        tck_fall = ~st_r.tck_s2 & st_r.tck_d;
        bsr_sel = bscan_bsr_sel(st_r.ir);
        st_nxt = st_r;
        st_nxt.tck_s1 = tck;
        st_nxt.tck_s2 = st_r.tck_s1;
        st_nxt.tck_d = st_r.tck_s2;
        st_nxt.tms_s1 = tms;
        st_nxt.tms_s2 = st_r.tms_s1;
        st_nxt.tdi_s1 = tdi;
        st_nxt.tdi_s2 = st_r.tdi_s1;
        st_nxt.capture = 1'b0;
        st_nxt.shift = 1'b0;
        st_nxt.update = 1'b0;
        st_nxt.sdi = st_r.tdi_s2;
        if (tck_rise) begin
            st_nxt.state = bscan_next(st_r.state, st_r.tms_s2); // [RULE_04] [RULE_15]
            unique case (st_r.state)
                bscan_pkg::BSCAN_RESET: begin
                    st_nxt.ir = bscan_pkg::IR_BYPASS; // [RULE_14]
                end
                bscan_pkg::BSCAN_CAP_IR: begin
                    st_nxt.ir_sh = bscan_pkg::IR_CAPTURE_VAL;
                end
                bscan_pkg::BSCAN_SH_IR: begin
                    st_nxt.ir_sh = {st_r.tdi_s2, st_r.ir_sh[2:1]}; // [RULE_05]
                end
                bscan_pkg::BSCAN_UPD_IR: begin
                    st_nxt.ir = st_r.ir_sh; // [RULE_15]
                end
                bscan_pkg::BSCAN_CAP_DR: begin
                    st_nxt.byp = 1'b0;
                    st_nxt.capture = bsr_sel; // [RULE_09] [RULE_10]
                end
                bscan_pkg::BSCAN_SH_DR: begin
                    st_nxt.byp = st_r.tdi_s2; // [RULE_13] [RULE_05]
                    st_nxt.shift = bsr_sel; // [RULE_05]
                end
                bscan_pkg::BSCAN_UPD_DR: begin
                    st_nxt.update = bsr_sel; // [RULE_10]
                end
                default: ;
            endcase
        end
        if (tck_fall) begin
            // launch on the falling edge, tester samples on the next rise
            unique case (st_r.state)
                bscan_pkg::BSCAN_SH_IR: begin
                    st_nxt.tdo = st_r.ir_sh[0]; // [RULE_06]
                end
                bscan_pkg::BSCAN_SH_DR: begin
                    st_nxt.tdo = bsr_sel ? ctl.sdo : st_r.byp; // [RULE_06] [RULE_13] [RULE_02]
                end
                default: ;
            endcase
            st_nxt.tdo_oe = bscan_in_shift(st_r.state); // [RULE_08]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
            st_r.state <= bscan_pkg::BSCAN_RESET; // [RULE_14]
            st_r.ir <= bscan_pkg::IR_BYPASS;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ctl.capture = st_r.capture;
    assign ctl.shift = st_r.shift;
    assign ctl.update = st_r.update;
    assign ctl.sdi = st_r.sdi;
    assign ctl.pins_from_cells = bscan_pins_sel(st_r.ir); // [RULE_09] [RULE_12]
    assign ctl.core_from_cells = bscan_core_sel(st_r.ir); // [RULE_09]
    assign ctl.all_highz = (st_r.ir == bscan_pkg::IR_HIGHZ); // [RULE_11]

    bscan_chain #(
        .NUM_IO(NUM_IO)
    ) u_chain (
        .clk(clk),
        .reset(reset),
        .ctl(ctl),
        .pad_in(pad_in),
        .core_out(core_out),
        .core_oe(core_oe),
        .core_in(core_in),
        .pad_out(pad_out),
        .pad_oe(pad_oe)
    );

    assign tdo = st_r.tdo;
    assign tdo_oe = st_r.tdo_oe;
endmodule

// ### dv/bscan_tester.sv
// board-side test controller model: drives tck, tms, tdi and reads tdo
// assumes clk is the bench clock; tck is built from it at 8 clk a period
`timescale 1ns/1ns
module bscan_tester (
    input wire logic clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic tdo_w;
    // released tdo reads as the pull-up level, never the stale bit
    assign tdo_w = tdo_oe ? tdo : 1'b1;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // 160 ns period, well under the cap; tck idles low between frames
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(posedge clk);
        #1;
        q = tdo_w;
        tck = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        tck = 1'b0;
    endtask
    task automatic tap_reset();
        logic q;
        for (int i = 0; i < 7; i++) begin
            step(1'b1, 1'b1, q);
        end
        step(1'b0, 1'b1, q);
    endtask
    task automatic scan(input logic ir, input int n, input logic [7:0] din, output logic [7:0] dout);
        logic q;
        dout = 8'h00;
        step(1'b1, 1'b1, q);
        if (ir) begin
            step(1'b1, 1'b1, q);
        end
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
endmodule

// ### dv/bscan_tap_chk.sv
// port checker for bscan_tap
// assumes tck moves a fixed delay after clk
`timescale 1ns/1ns
module bscan_tap_chk #(
    parameter int NUM_IO = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [NUM_IO-1:0] pad_in,
    input wire logic [NUM_IO-1:0] core_out,
    input wire logic [NUM_IO-1:0] core_oe,
    input wire logic [NUM_IO-1:0] core_in,
    input wire logic [NUM_IO-1:0] pad_out,
    input wire logic [NUM_IO-1:0] pad_oe
);
    logic tck_r;
    // tms-high tck rises in a row, saturating at 7
    logic [2:0] hi_cnt_r;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    always_ff @(posedge clk) begin
        tck_r <= tck;
        hi_cnt_r <= reset ? 3'h0 : !(tck && !tck_r) ? hi_cnt_r : !tms ? 3'h0 : hi_cnt_r + 3'(hi_cnt_r != 3'h7);
    end
    property p_rst_quiet;
        disable iff (1'b0) reset |=> !tdo_oe && !tdo && pad_oe == '0 && pad_out == '0 && core_in == '0;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("active in reset");
    property p_tdo_fall;
        $changed(tdo) |-> $past(tck, 6) && !$past(tck, 3);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo off fall");
    property p_oe_fall;
        $changed(tdo_oe) |-> $past(tck, 6) && !$past(tck, 3);
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("oe off fall");
    property p_oe_rise;
        $rose(tdo_oe) |-> hi_cnt_r == 3'h0;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("oe without shift");
    property p_oe_exit;
        hi_cnt_r >= 3'h3 |-> !tdo_oe;
    endproperty
    a_oe_exit: assert property (p_oe_exit) else $error("oe after exit");
    property p_tdo_hold;
        !tdo_oe |-> $stable(tdo);
    endproperty
    a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved idle");
    property p_pad_follow;
        hi_cnt_r == 3'h7 |-> pad_out == $past(core_out) && pad_oe == $past(core_oe);
    endproperty
    a_pad_follow: assert property (p_pad_follow) else $error("pads off core");
    property p_core_follow;
        hi_cnt_r == 3'h7 |-> core_in == $past(pad_in, 3);
    endproperty
    a_core_follow: assert property (p_core_follow) else $error("core_in off pads");
endmodule

// ### dv/bscan_tap_tb.sv
// self-checking bench for bscan_tap with two i/o
// assumes the tester model owns tck, tms and tdi
`timescale 1ns/1ns
module bscan_tap_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe;
    logic [1:0] pad_in = 2'h1;
    logic [1:0] core_out = 2'h2;
    logic [1:0] core_oe = 2'h3;
    logic [1:0] core_in, pad_out, pad_oe;
    logic [7:0] got;
    int fails = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    bscan_tap #(.NUM_IO(2)) i_bscan_tap (.clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .core_out(core_out), .core_oe(core_oe),
        .core_in(core_in), .pad_out(pad_out), .pad_oe(pad_oe));
    bscan_tester i_bscan_tester (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic pads(input logic [1:0] o, input logic [1:0] e);
        check(8'(pad_out), 8'(o));
        check(8'(pad_oe), 8'(e));
    endtask
    task automatic wait6();
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic load(input logic [2:0] c);
        i_bscan_tester.scan(1'b1, 3, 8'(c), got);
        check(got, 8'h01);
        wait6();
    endtask
    task automatic byp();
        i_bscan_tester.scan(1'b0, 4, 8'h0b, got);
        check(got, 8'h06);
    endtask
    task automatic t_reset();
        repeat (10) @(posedge clk);
        #1;
        check(8'({tdo_oe, pad_oe, pad_out, core_in}), 8'h00);
        reset = 1'b0;
        $display("t_reset done");
    endtask
    task automatic t_normal();
        i_bscan_tester.tap_reset();
        pads(core_out, core_oe);
        check(8'(core_in), 8'(pad_in));
        $display("t_normal done");
    endtask
    task automatic t_codes();
        logic [2:0] codes[4] = '{3'h7, 3'h2, 3'h3, 3'h4};
        foreach (codes[i]) begin
            load(codes[i]);
            byp();
            pads(core_out, core_oe);
        end
        $display("t_codes done");
    endtask
    task automatic t_sample();
        load(bscan_pkg::IR_SAMPLE);
        i_bscan_tester.scan(1'b0, 6, 8'h36, got);
        check(got, 8'h35);
        wait6();
        pads(2'h2, 2'h3);
        $display("t_sample done");
    endtask
    task automatic t_extest();
        load(bscan_pkg::IR_EXTEST);
        pads(2'h3, 2'h3);
        pad_in = 2'h2;
        i_bscan_tester.scan(1'b0, 6, 8'h0d, got);
        check(8'({got[3], got[0]}), 8'h02);
        wait6();
        pads(2'h0, 2'h1);
        check(8'(core_in), 8'h03);
        $display("t_extest done");
    endtask
    task automatic t_clamp();
        load(bscan_pkg::IR_CLAMP);
        core_out = 2'h1;
        wait6();
        pads(2'h0, 2'h1);
        byp();
        $display("t_clamp done");
    endtask
    task automatic t_highz();
        load(bscan_pkg::IR_HIGHZ);
        check(8'(pad_oe), 8'h00);
        check(8'(core_in), 8'(pad_in));
        byp();
        $display("t_highz done");
    endtask
    initial begin
        t_reset();
        t_normal();
        t_codes();
        t_sample();
        t_extest();
        t_clamp();
        t_highz();
        t_normal();
        give_verdict();
    end
    initial begin
        repeat (50000) @(posedge clk);
        check(8'h00, 8'h01);
        give_verdict();
    end
endmodule
bind bscan_tap bscan_tap_chk #(.NUM_IO(NUM_IO)) i_bscan_tap_chk (.clk(clk), .reset(reset), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .core_out(core_out),
    .core_oe(core_oe), .core_in(core_in), .pad_out(pad_out), .pad_oe(pad_oe));
